/* common/pid_reg_pkg.sv */
package pid_reg_pkg;
  typedef logic signed [47:0] wide_t;

  // register byte offsets
  localparam logic [7:0] OFS_SRC = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_TARGET = 8'h08;
  localparam logic [7:0] OFS_FB_GAIN = 8'h0C;
  localparam logic [7:0] OFS_P_GAIN = 8'h10;
  localparam logic [7:0] OFS_I_TIME = 8'h14;
  localparam logic [7:0] OFS_D_TIME = 8'h18;
  localparam logic [7:0] OFS_BIAS = 8'h1C;
  localparam logic [7:0] OFS_DELAY = 8'h20;
  localparam logic [7:0] OFS_I_LIMIT = 8'h24;
  localparam logic [7:0] OFS_OUT_LIMIT = 8'h28;
  localparam logic [7:0] OFS_OUT_GAIN = 8'h2C;
  localparam logic [7:0] OFS_RAMP = 8'h30;
  localparam logic [7:0] OFS_FB_MAX = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam logic [7:0] OFS_MONITOR = 8'h3C;

  // field positions
  localparam int SRC_SP_LSB = 0;
  localparam int SRC_FB_LSB = 4;
  localparam int SRC_PUMP_LSB = 8;
  localparam int SRC_SIMPLE_BIT = 12;
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_POL_BIT = 1;
  localparam int MODE_DSRC_BIT = 2;
  localparam int MODE_ADD_BIT = 3;
  localparam int MODE_REV_BIT = 4;
  localparam int FBMAX_DEC_LSB = 16;

  typedef enum logic [2:0] {
    SP_KEYPAD = 3'h0, SP_AIN1 = 3'h1, SP_AIN2 = 3'h2,
    SP_STORED = 3'h4, SP_FREQ = 3'h6, SP_MULTI = 3'h7
  } sp_src_t;

  typedef enum logic [2:0] {
    FB_AIN1 = 3'h1, FB_AIN2 = 3'h2, FB_DIFF = 3'h4
  } fb_src_t;

  typedef struct packed {
    logic [2:0] sp_src;
    logic [2:0] fb_src;
    logic [1:0] pump_sel;
    logic simple_disp;
    logic [4:0] mode;
    logic [15:0] target;
    logic [15:0] fb_gain;
    logic [15:0] p_gain;
    logic [15:0] i_time;
    logic [15:0] d_time;
    logic [15:0] bias;
    logic [15:0] delay;
    logic [15:0] i_limit;
    logic [15:0] out_limit;
    logic [15:0] out_gain;
    logic [15:0] ramp;
    logic [15:0] fb_max;
    logic [1:0] dec_width;
  } cfg_t;

  typedef struct packed {
    logic [11:0] ain1;
    logic [11:0] ain2;
    logic [15:0] freq_ref;
    logic [15:0] rated_freq;
    logic [15:0] max_freq;
    logic [15:0] multi_freq;
    logic [15:0] keypad_target;
    logic running;
  } drive_in_t;

  // reset values
  localparam cfg_t CFG_RST = '{
    sp_src: 3'h1, fb_src: 3'h2, pump_sel: 2'h0, simple_disp: 1'h1,
    mode: 5'h00, target: 16'h0000, fb_gain: 16'h0064,
    p_gain: 16'h0064, i_time: 16'h000A, d_time: 16'h0000,
    bias: 16'h0000, delay: 16'h0000, i_limit: 16'h03E8,
    out_limit: 16'h03E8, out_gain: 16'h000A, ramp: 16'h0000,
    fb_max: 16'h03E7, dec_width: 2'h1
  };

  // scaling: percent values held in 0.01 % steps
  localparam wide_t PCT_FULL = 48'sh2710;
  localparam wide_t AIN_FULL = 48'sh0FFF;
  localparam wide_t I_FRAC = 48'sh400;
  localparam wide_t HUNDRED = 48'sh64;
  localparam wide_t TEN = 48'shA;
  localparam wide_t FB_MAX_LIM = 48'sh3E8;
  localparam wide_t FREQ_MAX = 48'shFFFF;
  localparam wide_t US_PER_CENTI_S = 48'sh2710;
  localparam wide_t US_PER_DECI_S = 48'sh186A0;

  // control sample period
  localparam int CLK_HZ = 25000000;
  localparam int SAMPLE_US = 1000;
  localparam int SAMPLE_CYC_DEF = SAMPLE_US * (CLK_HZ / 1000000);
endpackage : pid_reg_pkg

/* verilog/process_pid_regulator.sv */
// Contract
// (RULE1) setpoint source 0 keypad,1/2 analog,4 stored,6 freq,7 multi-speed
// (RULE2) analog input 0..10 V maps linearly onto 0..100 % setpoint
// (RULE3) stored setpoint held as percentage 0.0..100.0
// (RULE4) frequency setpoint is reference over rated frequency in percent
// (RULE5) keypad target used only with pump function 1 or 2
// (RULE6) feedback source 1/2 analog input, 4 input one minus input two
// (RULE7) same input for setpoint and feedback raises conflict alarm
// (RULE8) negative input difference feedback clamps to zero
// (RULE9) mode bit 0 enables the regulator
// (RULE10) mode bit 1 inverts the output polarity
// (RULE11) mode bit 2 moves derivative from error onto feedback
// (RULE12) bit 3 low: output alone, 100 % equals maximum frequency
// (RULE13) bit 3 high: output added to command while running
// (RULE14) proportional term is error times gain 0.00..10.00
// (RULE15) integral accumulates error, longer time slower, 0.0..100.0 s
// (RULE16) derivative scales input rate by 0.00..10.00 s, added to sum
// (RULE17) reversal selector forbids or allows negative output reversing
// (RULE18) setpoint changes ramp with time 0.0..25.5 s
// (RULE19) simple display off flags alarm unless max below 1000, width 1
// (RULE20) integral term clamped to integral limit
// (RULE21) regulator output clamped to output limit
// (RULE22) limited output passes first-order low-pass by delay time
// (RULE23) bias -100..100 % added, scaled by output gain
// (RULE24) disabled: integral and derivative cleared, command passes
// (RULE25) feedback multiplied by gain 0.01..10.00 before error
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module process_pid_regulator
  import pid_reg_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire drive_in_t drive_in,
  output logic [15:0] freq_demand,
  output logic reverse_dir,
  output logic setting_conflict_alarm
);

  localparam wide_t SAMPLE_W = wide_t'(SAMPLE_US);

  function automatic wide_t clamp(input wide_t x, input wide_t lim);
    clamp = (x > lim) ? lim : ((x < -lim) ? -lim : x);
  endfunction : clamp

  function automatic wide_t nz(input wide_t x);
    nz = (x == 48'sh0) ? 48'sh1 : x;
  endfunction : nz

  // apb slave and configuration
  cfg_t cfg_q, cfg_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [15:0] freq_q, freq_d;
  logic rev_q, rev_d;
  logic alarm_q, alarm_d;
  wide_t sp_q, sp_d;
  wide_t fb_q, fb_d;

  always_comb begin
    logic hit;
    logic setup;
    logic wr;
    hit = 1'b1;
    setup = psel & ~penable;
    wr = psel & penable & pready_q & pwrite;
    cfg_d = cfg_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = setup;
    case (paddr)
      OFS_SRC: prdata_d = {19'h0, cfg_q.simple_disp, 2'h0,
        cfg_q.pump_sel, 1'h0, cfg_q.fb_src, 1'h0, cfg_q.sp_src};
      OFS_MODE: prdata_d = {27'h0, cfg_q.mode};
      OFS_TARGET: prdata_d = {16'h0, cfg_q.target};
      OFS_FB_GAIN: prdata_d = {16'h0, cfg_q.fb_gain};
      OFS_P_GAIN: prdata_d = {16'h0, cfg_q.p_gain};
      OFS_I_TIME: prdata_d = {16'h0, cfg_q.i_time};
      OFS_D_TIME: prdata_d = {16'h0, cfg_q.d_time};
      OFS_BIAS: prdata_d = {16'h0, cfg_q.bias};
      OFS_DELAY: prdata_d = {16'h0, cfg_q.delay};
      OFS_I_LIMIT: prdata_d = {16'h0, cfg_q.i_limit};
      OFS_OUT_LIMIT: prdata_d = {16'h0, cfg_q.out_limit};
      OFS_OUT_GAIN: prdata_d = {16'h0, cfg_q.out_gain};
      OFS_RAMP: prdata_d = {16'h0, cfg_q.ramp};
      OFS_FB_MAX: prdata_d = {14'h0, cfg_q.dec_width, cfg_q.fb_max};
      OFS_STATUS: prdata_d = {freq_q, 14'h0, rev_q, alarm_q};
      OFS_MONITOR: prdata_d = {fb_q[15:0], sp_q[15:0]};
      default: begin
        hit = 1'b0;
        prdata_d = 32'h0;
      end
    endcase
    if (!setup) begin
      prdata_d = prdata_q;
    end
    if (setup && !hit) begin
      pslverr_d = 1'b1;
    end
    if (pready_q && !setup) begin
      pslverr_d = pslverr_q & psel & penable;
    end
    if (wr) begin
      case (paddr)
        OFS_SRC: begin
          cfg_d.sp_src = pwdata[SRC_SP_LSB +: 3]; // RULE1
          cfg_d.fb_src = pwdata[SRC_FB_LSB +: 3]; // RULE6
          cfg_d.pump_sel = pwdata[SRC_PUMP_LSB +: 2];
          cfg_d.simple_disp = pwdata[SRC_SIMPLE_BIT];
        end
        OFS_MODE: cfg_d.mode = pwdata[4:0];
        OFS_TARGET: cfg_d.target = pwdata[15:0];
        OFS_FB_GAIN: cfg_d.fb_gain = pwdata[15:0];
        OFS_P_GAIN: cfg_d.p_gain = pwdata[15:0];
        OFS_I_TIME: cfg_d.i_time = pwdata[15:0];
        OFS_D_TIME: cfg_d.d_time = pwdata[15:0];
        OFS_BIAS: cfg_d.bias = pwdata[15:0];
        OFS_DELAY: cfg_d.delay = pwdata[15:0];
        OFS_I_LIMIT: cfg_d.i_limit = pwdata[15:0];
        OFS_OUT_LIMIT: cfg_d.out_limit = pwdata[15:0];
        OFS_OUT_GAIN: cfg_d.out_gain = pwdata[15:0];
        OFS_RAMP: cfg_d.ramp = pwdata[15:0];
        OFS_FB_MAX: begin
          cfg_d.fb_max = pwdata[15:0];
          cfg_d.dec_width = pwdata[FBMAX_DEC_LSB +: 2];
        end
        default: cfg_d = cfg_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RST;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // sample tick
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 32'h1;
    if (tick_cnt_q >= 32'(SAMPLE_CYC - 1)) begin
      tick_cnt_d = 32'h0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // control loop
  wide_t i_q, i_d;
  wide_t dx_prev_q, dx_prev_d;
  wide_t filt_q, filt_d;

  always_comb begin
    wide_t a1;
    wide_t a2;
    wide_t sp_raw;
    wide_t fb_raw;
    wide_t step;
    wide_t err;
    wide_t dx;
    wide_t p;
    wide_t d;
    wide_t sum;
    wide_t out;
    wide_t ilim;
    wide_t total;
    wide_t mag;
    wide_t freq_in;
    logic run_loop;
    logic neg;
    a1 = 48'sh0;
    a2 = 48'sh0;
    sp_raw = 48'sh0;
    fb_raw = 48'sh0;
    step = 48'sh0;
    err = 48'sh0;
    dx = 48'sh0;
    p = 48'sh0;
    d = 48'sh0;
    sum = 48'sh0;
    out = 48'sh0;
    ilim = 48'sh0;
    total = 48'sh0;
    mag = 48'sh0;
    freq_in = 48'sh0;
    run_loop = 1'b0;
    neg = 1'b0;

    // analog scaling
    a1 = wide_t'(drive_in.ain1) * PCT_FULL / AIN_FULL; // RULE2
    a2 = wide_t'(drive_in.ain2) * PCT_FULL / AIN_FULL; // RULE2
    freq_in = wide_t'(drive_in.freq_ref);

    // setpoint select
    sp_raw = 48'sh0;
    case (cfg_q.sp_src) // RULE1
      SP_KEYPAD: begin
        if (cfg_q.pump_sel == 2'h1 || cfg_q.pump_sel == 2'h2) begin
          sp_raw = wide_t'(drive_in.keypad_target) * TEN; // RULE5
        end
      end
      SP_AIN1: sp_raw = a1;
      SP_AIN2: sp_raw = a2;
      SP_STORED: sp_raw = wide_t'(cfg_q.target) * TEN; // RULE3
      SP_FREQ: sp_raw = freq_in * PCT_FULL
        / nz(wide_t'(drive_in.rated_freq)); // RULE4
      SP_MULTI: sp_raw = wide_t'(drive_in.multi_freq) * PCT_FULL
        / nz(wide_t'(drive_in.rated_freq)); // RULE4
      default: sp_raw = 48'sh0;
    endcase
    sp_raw = (sp_raw > PCT_FULL) ? PCT_FULL : sp_raw; // RULE3

    // feedback select
    case (cfg_q.fb_src) // RULE6
      FB_AIN1: fb_raw = a1;
      FB_AIN2: fb_raw = a2;
      FB_DIFF: fb_raw = (a1 > a2) ? a1 - a2 : 48'sh0; // RULE8
      default: fb_raw = 48'sh0;
    endcase
    fb_d = fb_raw * wide_t'(cfg_q.fb_gain) / HUNDRED; // RULE25

    // setting conflict checks
    alarm_d = 1'b0;
    if (cfg_q.sp_src == cfg_q.fb_src && (cfg_q.sp_src == SP_AIN1
        || cfg_q.sp_src == SP_AIN2)) begin
      alarm_d = 1'b1; // RULE7
    end
    if (cfg_q.fb_src == FB_DIFF && (cfg_q.sp_src == SP_AIN1
        || cfg_q.sp_src == SP_AIN2)) begin
      alarm_d = 1'b1; // RULE7
    end
    if (!cfg_q.simple_disp && !(wide_t'(cfg_q.fb_max) < FB_MAX_LIM
        && cfg_q.dec_width == 2'h1)) begin
      alarm_d = 1'b1; // RULE19
    end

    // loop enable
    run_loop = cfg_q.mode[MODE_EN_BIT] & ~alarm_q; // RULE9
    if (cfg_q.mode[MODE_ADD_BIT] && !drive_in.running) begin
      run_loop = 1'b0; // RULE13
    end
    sp_d = sp_q;
    i_d = i_q;
    dx_prev_d = dx_prev_q;
    filt_d = filt_q;
    freq_d = freq_q;
    rev_d = rev_q;

    // setpoint ramp step per sample
    step = PCT_FULL * SAMPLE_W
      / nz(wide_t'(cfg_q.ramp) * US_PER_DECI_S);
    step = (step < 48'sh1) ? 48'sh1 : step;

    // pid terms
    err = sp_q - fb_q;
    if (cfg_q.mode[MODE_POL_BIT]) begin
      err = -err; // RULE10
    end
    dx = cfg_q.mode[MODE_DSRC_BIT] ? -fb_q : err; // RULE11
    p = err * wide_t'(cfg_q.p_gain) / HUNDRED; // RULE14
    d = (dx - dx_prev_q) * wide_t'(cfg_q.d_time)
      * US_PER_CENTI_S / SAMPLE_W; // RULE16
    ilim = wide_t'(cfg_q.i_limit) * TEN * I_FRAC; // RULE20
    sum = clamp(p + i_q / I_FRAC + d,
      wide_t'(cfg_q.out_limit) * TEN); // RULE16 RULE21

    // output stage
    out = (filt_q + wide_t'($signed(cfg_q.bias)) * HUNDRED)
      * wide_t'(cfg_q.out_gain) / TEN; // RULE23
    if (cfg_q.mode[MODE_ADD_BIT]) begin
      total = freq_in + out * wide_t'(drive_in.max_freq)
        / PCT_FULL; // RULE13
    end else begin
      total = out * wide_t'(drive_in.max_freq) / PCT_FULL; // RULE12
    end
    neg = total < 48'sh0;
    mag = neg ? -total : total;
    if (neg && !cfg_q.mode[MODE_REV_BIT]) begin
      mag = 48'sh0; // RULE17
      neg = 1'b0;
    end
    mag = (mag > FREQ_MAX) ? FREQ_MAX : mag;

    // sample update
    if (tick_q) begin
      if (cfg_q.ramp == 16'h0 || sp_raw - sp_q <= step
          && sp_q - sp_raw <= step) begin
        sp_d = sp_raw; // RULE18
      end else if (sp_raw > sp_q) begin
        sp_d = sp_q + step; // RULE18
      end else begin
        sp_d = sp_q - step; // RULE18
      end
      if (cfg_q.i_time != 16'h0) begin
        i_d = clamp(i_q + err * SAMPLE_W * I_FRAC
          / (wide_t'(cfg_q.i_time) * US_PER_DECI_S), ilim); // RULE15
      end else begin
        i_d = 48'sh0;
      end
      dx_prev_d = dx;
      filt_d = filt_q + (sum - filt_q) * SAMPLE_W
        / (wide_t'(cfg_q.delay) * US_PER_CENTI_S + SAMPLE_W); // RULE22
      freq_d = mag[15:0];
      rev_d = neg; // RULE17
    end

    // disabled path
    if (!run_loop) begin
      i_d = 48'sh0; // RULE24
      dx_prev_d = 48'sh0; // RULE24
      filt_d = 48'sh0;
      freq_d = drive_in.freq_ref; // RULE24
      rev_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= 48'sh0;
      fb_q <= 48'sh0;
      i_q <= 48'sh0;
      dx_prev_q <= 48'sh0;
      filt_q <= 48'sh0;
      freq_q <= 16'h0;
      rev_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      sp_q <= sp_d;
      fb_q <= fb_d;
      i_q <= i_d;
      dx_prev_q <= dx_prev_d;
      filt_q <= filt_d;
      freq_q <= freq_d;
      rev_q <= rev_d;
      alarm_q <= alarm_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign freq_demand = freq_q;
  assign reverse_dir = rev_q;
  assign setting_conflict_alarm = alarm_q;

endmodule : process_pid_regulator

/* tb/process_pid_regulator_monitor.sv */
`timescale 1ns/1ps
module process_pid_regulator_monitor
  import pid_reg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire drive_in_t drive_in,
  input wire logic [15:0] freq_demand,
  input wire logic reverse_dir,
  input wire logic setting_conflict_alarm
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence setup_s;
    psel && !penable;
  endsequence

  sequence clash_wr_s;
    setup_s ##1 psel && penable && pwrite && paddr == OFS_SRC &&
      pwdata[2:0] inside {3'h1, 3'h2} &&
      (pwdata[6:4] == pwdata[2:0] || pwdata[6:4] == 3'h4);
  endsequence

  ready_after_setup_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_cause_a: assert property (
    pready |-> $past(psel && !penable) && psel && penable)
    else $error("ready without access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  unmapped_err_a: assert property (
    (setup_s and paddr > 8'h3C) |=> pready && pslverr && prdata == '0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (
    (setup_s and paddr <= 8'h3C && paddr[1:0] == 2'b00) |=> !pslverr)
    else $error("mapped access refused");
  status_read_a: assert property (
    (setup_s and !pwrite && paddr == OFS_STATUS) |=>
      prdata[31:16] == $past(freq_demand) &&
      prdata[1] == $past(reverse_dir) &&
      prdata[0] == $past(setting_conflict_alarm))
    else $error("status read mismatch");
  conflict_alarm_a: assert property (
    clash_wr_s |-> ##[1:2] setting_conflict_alarm)
    else $error("conflict not flagged");
  alarm_pass_a: assert property (
    setting_conflict_alarm && $past(setting_conflict_alarm) |->
      freq_demand == $past(drive_in.freq_ref) && !reverse_dir)
    else $error("command not passed while off");
endmodule : process_pid_regulator_monitor

/* tb/process_pid_regulator_bench.sv */
`timescale 1ns/1ps
module process_pid_regulator_bench;
  import pid_reg_pkg::*;
  localparam logic [31:0] RST_V [14] = '{32'h1021, 32'h0, 32'h0, 32'h64,
    32'h64, 32'hA, 32'h0, 32'h0, 32'h0, 32'h3E8, 32'h3E8, 32'hA, 32'h0,
    32'h103E7};
  localparam logic [31:0] BAD [4] = '{32'h1011, 32'h1022, 32'h1041, 32'h1042};
  localparam logic [31:0] FBM [3] = '{32'h103E7, 32'h103E8, 32'h203E7};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  drive_in_t din;
  logic [15:0] freq_demand;
  logic reverse_dir;
  logic setting_conflict_alarm;
  logic [31:0] rsp;
  logic err;
  logic [15:0] slow_fd;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;

  process_pid_regulator #(.SAMPLE_CYC(20)) process_pid_regulator_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive_in(din),
    .freq_demand(freq_demand), .reverse_dir(reverse_dir),
    .setting_conflict_alarm(setting_conflict_alarm)
  );

  always #20 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo,
      input logic [31:0] hi);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : chk_in

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rsp = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(32'(err), 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rsp, e);
  endtask : rd

  task automatic run(input logic [31:0] src, input logic [31:0] mode,
      input logic [31:0] tgt, input logic [15:0] fd, input logic rev);
    wr(OFS_SRC, src);
    wr(OFS_TARGET, tgt);
    wr(OFS_MODE, mode);
    repeat (200) @(posedge pclk);
    chk(32'(freq_demand), 32'(fd));
    chk(32'(reverse_dir), 32'(rev));
  endtask : run

  task automatic t_reset();
    for (int i = 0; i < 14; i++) begin
      rd(8'(4 * i), RST_V[i]);
    end
    rd(OFS_STATUS, {din.freq_ref, 16'h0});
    apb(1'b0, 8'h40, 32'h0);
    chk(rsp, 32'h0);
    chk(32'(err), 32'h1);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd(OFS_STATUS, {din.freq_ref, 16'h0});
  endtask : t_reset

  task automatic t_alarm();
    wr(OFS_MODE, 32'h1);
    foreach (BAD[i]) begin
      wr(OFS_SRC, BAD[i]);
      repeat (3) @(posedge pclk);
      chk(32'(setting_conflict_alarm), 32'h1);
      chk(32'(freq_demand), 32'(din.freq_ref));
    end
    wr(OFS_SRC, 32'h0014);
    foreach (FBM[i]) begin
      wr(OFS_FB_MAX, FBM[i]);
      repeat (3) @(posedge pclk);
      chk(32'(setting_conflict_alarm), 32'(i != 0));
    end
    wr(OFS_FB_MAX, 32'h103E7);
  endtask : t_alarm

  task automatic t_sources();
    wr(OFS_I_TIME, 32'h0);
    din.ain1 <= 12'hFFF;
    run(32'h1021, 32'h1, 32'h0, 16'h1770, 1'b0);
    din.ain1 <= 12'h000;
    din.ain2 <= 12'hFFF;
    run(32'h1012, 32'h1, 32'h0, 16'h1770, 1'b0);
    run(32'h1044, 32'h1, 32'h1F4, 16'h0BB8, 1'b0);
    rd(OFS_MONITOR, 32'h0000_1388);
    din.ain2 <= 12'h000;
    din.freq_ref <= 16'h0BB8;
    run(32'h1016, 32'h1, 32'h0, 16'h0BB8, 1'b0);
    din.multi_freq <= 16'h05DC;
    run(32'h1017, 32'h1, 32'h0, 16'h05DC, 1'b0);
    din.keypad_target <= 16'h01F4;
    run(32'h1110, 32'h1, 32'h0, 16'h0BB8, 1'b0);
  endtask : t_sources

  task automatic t_shape();
    run(32'h1014, 32'h3, 32'h1F4, 16'h0, 1'b0);
    run(32'h1014, 32'h13, 32'h1F4, 16'h0BB8, 1'b1);
    wr(OFS_P_GAIN, 32'hC8);
    run(32'h1014, 32'h1, 32'h1F4, 16'h1770, 1'b0);
    wr(OFS_OUT_LIMIT, 32'hFA);
    run(32'h1014, 32'h1, 32'h1F4, 16'h05DC, 1'b0);
    wr(OFS_OUT_LIMIT, 32'h3E8);
    wr(OFS_P_GAIN, 32'h64);
    wr(OFS_FB_GAIN, 32'h32);
    din.ain1 <= 12'hFFF;
    run(32'h1014, 32'h1, 32'h3E8, 16'h0BB8, 1'b0);
    rd(OFS_MONITOR, 32'h1388_2710);
    wr(OFS_FB_GAIN, 32'h64);
    din.ain1 <= 12'h000;
    wr(OFS_BIAS, 32'h14);
    run(32'h1014, 32'h1, 32'h0, 16'h04B0, 1'b0);
    wr(OFS_BIAS, 32'h0);
  endtask : t_shape

  task automatic t_lim();
    wr(OFS_P_GAIN, 32'h0);
    wr(OFS_I_TIME, 32'h1);
    wr(OFS_I_LIMIT, 32'h32);
    run(32'h1014, 32'h1, 32'h3E8, 16'h012C, 1'b0);
    wr(OFS_I_LIMIT, 32'h3E8);
    wr(OFS_MODE, 32'h0);
  endtask : t_lim

  task automatic t_add();
    din.freq_ref <= 16'h03E8;
    din.running <= 1'b1;
    run(32'h1014, 32'h9, 32'h1F4, 16'h0FA0, 1'b0);
    din.running <= 1'b0;
    run(32'h1014, 32'h9, 32'h1F4, 16'h03E8, 1'b0);
    run(32'h1014, 32'h0, 32'h1F4, 16'h03E8, 1'b0);
  endtask : t_add

  task automatic t_slow();
    wr(OFS_P_GAIN, 32'h0);
    wr(OFS_I_TIME, 32'hA);
    wr(OFS_SRC, 32'h1014);
    wr(OFS_TARGET, 32'h1F4);
    wr(OFS_MODE, 32'h1);
    repeat (100) @(posedge pclk);
    chk_in(32'(freq_demand), 32'h0, 32'hBB7);
    repeat (100) @(posedge pclk);
    slow_fd = freq_demand;
    chk_in(32'(slow_fd), 32'h1, 32'hBB7);
    chk(32'(reverse_dir), 32'h0);
    wr(OFS_MODE, 32'h0);
    wr(OFS_I_TIME, 32'h64);
    wr(OFS_MODE, 32'h1);
    repeat (200) @(posedge pclk);
    chk_in(32'(freq_demand), 32'h1, 32'(slow_fd) - 32'h1);
    wr(OFS_P_GAIN, 32'h64);
    wr(OFS_I_TIME, 32'h0);
    wr(OFS_RAMP, 32'hA);
    wr(OFS_TARGET, 32'h3E8);
    repeat (200) @(posedge pclk);
    apb(1'b0, OFS_MONITOR, 32'h0);
    chk_in({16'h0, rsp[15:0]}, 32'h138A, 32'h26FF);
  endtask : t_slow

  initial begin
    din = '0;
    din.max_freq = 16'h1770;
    din.rated_freq = 16'h1770;
    din.freq_ref = 16'h03E8;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_alarm();
    t_sources();
    t_shape();
    t_add();
    t_lim();
    t_slow();
    end_of_test();
  end
endmodule : process_pid_regulator_bench

bind process_pid_regulator process_pid_regulator_monitor
  process_pid_regulator_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .drive_in(drive_in),
  .freq_demand(freq_demand), .reverse_dir(reverse_dir),
  .setting_conflict_alarm(setting_conflict_alarm)
);
